// ---- hdl/ncg_pkg.sv ----
package ncg_pkg;
  // control register addresses
  localparam logic [15:0] REG_DIV  = 16'h1820;
  localparam logic [15:0] REG_OPT  = 16'h1821;
  localparam logic [15:0] REG_PROT = 16'h1822;
  localparam logic [15:0] REG_STAT = 16'h1823;
  localparam logic [15:0] REG_CMD  = 16'h1824;
  // array windows
  localparam logic [15:0] EE_LO    = 16'h1600;
  localparam logic [15:0] EE_HI    = 16'h17ff;
  localparam logic [15:0] FL_LO    = 16'h1900;
  localparam logic [15:0] VEC_LO   = 16'hffc0;
  localparam logic [15:0] VEC_HI   = 16'hfffd;
  // nonvolatile byte locations
  localparam logic [15:0] NV_PROT_ADDR = 16'hffbd;
  localparam logic [15:0] NV_OPT_ADDR  = 16'hffbf;
  // status bit positions
  localparam int ST_CBEF   = 7;
  localparam int ST_CCF    = 6;
  localparam int ST_PVIOL  = 5;
  localparam int ST_ACCESS_ERROR_ALIAS = 4;
  // divider written flag, option redirect-disable bit
  localparam int DIV_DONE_BIT = 7;
  localparam int OPT_NORED    = 6;
  // protection fields: eeprom [7:5], flash [4:0]
  localparam int PROT_EE_LSB = 5;
  localparam int PROT_FL_MSB = 4;
  localparam int FL_SHIFT    = 9;
  localparam int EE_SHIFT    = 6;
  localparam int BLOCK_SHIFT = 5;
  // command codes
  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_PROG  = 8'h20;
  localparam logic [7:0] CMD_BURST = 8'h25;
  localparam logic [7:0] CMD_SECT  = 8'h40;
  localparam logic [7:0] CMD_MASS  = 8'h41;
  localparam logic [7:0] CMD_ABORT = 8'h47;
  // operation lengths in timing-clock ticks
  localparam logic [14:0] TICKS_PROG  = 15'h0009;
  localparam logic [14:0] TICKS_BURST = 15'h0004;
  localparam logic [14:0] TICKS_SECT  = 15'h0fa0;
  localparam logic [14:0] TICKS_ABORT = 15'h0004;
  localparam logic [14:0] TICKS_BLANK = 15'h0004;
  localparam int          TICKS_MASS_DEF = 20000;
  // reset values
  localparam logic [7:0] DIV_RST  = 8'h00;
  localparam logic [7:0] CMD_RST  = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // command entry phases
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ADDR = 2'b01,
    SEQ_CMD  = 2'b11
  } ncg_seq_t;
endpackage

// ---- hdl/ncg_nvm_command_guard.sv ----
// Chosen here: strobed register access.
`timescale 1ns/1ps
module ncg_nvm_command_guard
  import ncg_pkg::*;
#(
  parameter int unsigned TICKS_MASS = TICKS_MASS_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [15:0] busAddr,
  input  wire logic [7:0]  busWrData,
  input  wire logic        busWr,
  input  wire logic        busRd,
  output logic      [7:0]  busRdData,
  input  wire logic        bdmAccess,
  input  wire logic        secured,
  input  wire logic        stopReq,
  input  wire logic [7:0]  nvProtByte,
  input  wire logic [7:0]  nvOptByte,
  input  wire logic        vecFetch,
  input  wire logic [15:0] vecAddr,
  output logic      [15:0] vecAddrOut,
  output logic             pumpOn,
  output logic             arrayBusy
);

  ////////////////////////////////////////////////////////////////
  // helpers

  // address falls in either array window
  // flash window runs to the top of the map, so it needs no upper bound
  function automatic logic isArray(input logic [15:0] a);
    isArray = (a >= EE_LO && a <= EE_HI) || (a >= FL_LO);
  endfunction

  // one of the six accepted codes
  function automatic logic isLegal(input logic [7:0] c);
    isLegal = (c == CMD_BLANK) || (c == CMD_PROG) || (c == CMD_BURST) ||
              (c == CMD_SECT) || (c == CMD_MASS) || (c == CMD_ABORT);
  endfunction

  // standard duration of a command
  function automatic logic [14:0] ticksFor(input logic [7:0] c);
    case (c)
      CMD_PROG, CMD_BURST: ticksFor = TICKS_PROG;
      CMD_SECT:            ticksFor = TICKS_SECT;
      CMD_MASS:            ticksFor = 15'(TICKS_MASS);
      default:             ticksFor = TICKS_BLANK;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  // state

  logic [7:0]  div_reg;        // bit7 written flag, [6:0] divider
  logic [7:0]  opt_reg;        // working copy of option byte
  logic [7:0]  prot_reg;       // working protection ranges
  logic [7:0]  cmd_reg;        // last code accepted
  logic        loadPend_reg;   // copy nv bytes after reset
  logic        access_error_alias_reg;     // sticky access error
  logic        pViol_reg;      // protection violation
  ncg_seq_t    seq_reg;        // command entry phase
  ncg_seq_t    seq_next;
  logic [15:0] seqAddr_reg;    // latched array address
  logic        bufFull_reg;    // launched command waiting
  logic [7:0]  bufCmd_reg;
  logic [15:0] bufAddr_reg;
  logic        abortAct_reg;   // abort launched, not done
  logic        cutShort_reg;   // abort trimmed a sector erase
  logic        busy_reg;       // engine running
  logic [7:0]  runCmd_reg;
  logic [15:0] runAddr_reg;
  logic [14:0] opCnt_reg;      // ticks left
  logic [6:0]  pre_reg;        // timing prescaler
  logic        pump_reg;
  logic [7:0]  rd_reg;
  logic [15:0] vec_reg;

  ////////////////////////////////////////////////////////////////
  // bus decode

  wire arrWr  = busWr && isArray(busAddr);
  wire divWr  = busWr && (busAddr == REG_DIV);
  wire protWr = busWr && (busAddr == REG_PROT);
  wire statWr = busWr && (busAddr == REG_STAT);
  wire cmdWr  = busWr && (busAddr == REG_CMD);
  // every divider, protection, status or command write, for the order checks below
  wire ctrlWr = divWr || protWr || statWr || cmdWr;
  wire divDone = div_reg[DIV_DONE_BIT];
  wire cbef   = !bufFull_reg && !abortAct_reg;
  // done only when nothing runs, waits or is being aborted
  wire ccf    = !busy_reg && !bufFull_reg && !abortAct_reg;
  wire bdmBlocked = bdmAccess && secured &&
                    (busWrData != CMD_BLANK) && (busWrData != CMD_MASS);

  ////////////////////////////////////////////////////////////////
  // protocol violations

  // divider first; buffer must be free
  // abort still active also refuses array writes
  wire errArr = arrWr && (!divDone || !cbef || seq_reg != SEQ_IDLE);
  // only code after array write; legal codes
  wire errAddr = (seq_reg == SEQ_ADDR) &&
                 ((ctrlWr && !cmdWr) ||
                  (cmdWr && (!isLegal(busWrData) || bdmBlocked)));
  // only launch after code; zero is an error
  wire errCmd = (seq_reg == SEQ_CMD) &&
                ((ctrlWr && !statWr) || (statWr && !busWrData[ST_CBEF]));
  // stop with nothing running is harmless and leaves no error
  // stop kills running op
  wire errStop = stopReq && busy_reg;

  ////////////////////////////////////////////////////////////////
  // timing engine decode

  // one tick every divider+1 core cycles while busy
  // prescaler idles at zero so the first tick is a full period
  wire tick    = busy_reg && (pre_reg == div_reg[6:0]);
  wire finish  = tick && (opCnt_reg == 15'h0001);
  // trimmed erase reports error at completion
  wire errCut  = finish && cutShort_reg;
  wire errSet  = errArr || errAddr || errCmd || errStop || errCut;
  wire accClr  = statWr && busWrData[ST_ACCESS_ERROR_ALIAS];
  // a launch that would also raise an error is dropped whole
  wire launch  = statWr && busWrData[ST_CBEF] && (seq_reg == SEQ_CMD) &&
                 !access_error_alias_reg && !errSet;
  wire arrTake = arrWr && !access_error_alias_reg && !errSet;
  wire cmdTake = cmdWr && (seq_reg == SEQ_ADDR) && !access_error_alias_reg && !errSet;
  wire isAbort = (cmd_reg == CMD_ABORT);

  // next burst address: queued command or sequence in entry
  wire [15:0] nxtAddr = bufFull_reg ? bufAddr_reg : seqAddr_reg;
  // next sequence begun before done: queued burst, or any code in entry
  wire nxtStarted = bufFull_reg ? (bufCmd_reg == CMD_BURST) :
                    (seq_reg != SEQ_IDLE);
  // sequential and in same 32-byte block
  wire sameBlk = (nxtAddr == runAddr_reg + 16'h0001) &&
                 (nxtAddr[15:BLOCK_SHIFT] == runAddr_reg[15:BLOCK_SHIFT]);
  wire keepPump = (runCmd_reg == CMD_BURST) && nxtStarted && sameBlk;

  ////////////////////////////////////////////////////////////////
  // protection decode

  wire [4:0]  flRng  = prot_reg[PROT_FL_MSB:0];
  wire [2:0]  eeRng  = prot_reg[7:PROT_EE_LSB];
  // ranges grow in whole blocks: 512 bytes of flash, 64 of eeprom
  wire [15:0] flSize = 16'({flRng, 9'h000});
  wire [15:0] eeSize = 16'({eeRng, 6'h00});
  // bases carry a 17th bit so an empty flash range sits above the map
  wire [16:0] flBase = 17'h10000 - {1'b0, flSize};
  wire [16:0] eeBase = {1'b0, EE_HI} + 17'h00001 - {1'b0, eeSize};
  wire bufProt = (bufAddr_reg >= FL_LO && {1'b0, bufAddr_reg} >= flBase) ||
                 (bufAddr_reg >= EE_LO && bufAddr_reg <= EE_HI &&
                  {1'b0, bufAddr_reg} >= eeBase);
  wire anyProt = (flRng != 5'h00) || (eeRng != 3'h0);
  wire startBlk = (bufCmd_reg == CMD_MASS) ? anyProt :
                  ((bufCmd_reg != CMD_BLANK) && bufProt);
  // a protected start frees the buffer without running
  wire start = !busy_reg && bufFull_reg && !errStop;
  // fast time only while pump is held
  wire [14:0] startTicks = ((bufCmd_reg == CMD_BURST) && pump_reg) ?
                           TICKS_BURST : ticksFor(bufCmd_reg);
  // never shrink, except by debug
  // limitation: debug may lower protection whether or not secured
  wire protOk = bdmAccess ||
                ((busWrData[PROT_FL_MSB:0] >= flRng) &&
                 (busWrData[7:PROT_EE_LSB] >= eeRng));

  wire redirOn = !opt_reg[OPT_NORED] && (flRng != 5'h00);
  wire inVec   = (vecAddr >= VEC_LO) && (vecAddr <= VEC_HI);

  // status and readback
  // unmapped addresses read as zero rather than holding the bus
  wire [7:0] statVal = {cbef, ccf, pViol_reg, access_error_alias_reg, 4'h0};
  wire [7:0] rdMux = (busAddr == REG_DIV)  ? div_reg  :
                     (busAddr == REG_OPT)  ? opt_reg  :
                     (busAddr == REG_PROT) ? prot_reg :
                     (busAddr == REG_STAT) ? statVal  :
                     (busAddr == REG_CMD)  ? cmd_reg  : 8'h00;

  ////////////////////////////////////////////////////////////////
  // entry phase next state

  // entry walks idle, address, code; any fault sends it back to idle
  always_comb begin
    seq_next = seq_reg;
    if (access_error_alias_reg || errSet) begin
      seq_next = SEQ_IDLE;
    end else begin
      case (seq_reg)
        SEQ_IDLE: begin
          if (arrTake) begin
            seq_next = SEQ_ADDR;
          end
        end
        SEQ_ADDR: begin
          if (cmdTake) begin
            seq_next = SEQ_CMD;
          end
        end
        SEQ_CMD: begin
          if (launch) begin
            seq_next = SEQ_IDLE;
          end
        end
        default: seq_next = SEQ_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // configuration registers

  // divider writable once; nv copies taken one edge after reset
  // protection writes during entry are refused to keep the order strict
  always_ff @(posedge core_clk) begin
    if (srst) begin
      div_reg      <= DIV_RST;
      opt_reg      <= BYTE_RST;
      prot_reg     <= BYTE_RST;
      loadPend_reg <= 1'b1;
    end else begin
      if (divWr && !divDone && seq_reg == SEQ_IDLE) begin
        div_reg <= {1'b1, busWrData[6:0]};
      end
      if (loadPend_reg) begin
        prot_reg     <= nvProtByte;
        opt_reg      <= nvOptByte;
        loadPend_reg <= 1'b0;
      end else if (protWr && protOk && seq_reg == SEQ_IDLE) begin
        prot_reg <= busWrData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // flags and entry latches
  // one host write clears both flags; a new fault in that cycle wins

  always_ff @(posedge core_clk) begin
    if (srst) begin
      access_error_alias_reg  <= 1'b0;
      pViol_reg   <= 1'b0;
      seq_reg     <= SEQ_IDLE;
      seqAddr_reg <= 16'h0000;
      cmd_reg     <= CMD_RST;
    end else begin
      access_error_alias_reg <= errSet || (access_error_alias_reg && !accClr);
      pViol_reg <= (start && startBlk) || (pViol_reg && !accClr);
      seq_reg <= seq_next;
      if (arrTake) begin
        seqAddr_reg <= busAddr;
      end
      if (cmdTake) begin
        cmd_reg <= busWrData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // command buffer and abort tracking
  // the abort never enters the buffer, it acts on the running op

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bufFull_reg  <= 1'b0;
      bufCmd_reg   <= CMD_RST;
      bufAddr_reg  <= 16'h0000;
      abortAct_reg <= 1'b0;
      cutShort_reg <= 1'b0;
    end else if (errStop) begin
      // stop flushes everything queued
      bufFull_reg  <= 1'b0;
      abortAct_reg <= 1'b0;
      cutShort_reg <= 1'b0;
    end else begin
      if (launch && !isAbort) begin
        bufFull_reg <= 1'b1;
        bufCmd_reg  <= cmd_reg;
        bufAddr_reg <= seqAddr_reg;
      end else if (start) begin
        bufFull_reg <= 1'b0;
      end
      // abort launch only marks the engine
      if (launch && isAbort) begin
        abortAct_reg <= 1'b1;
        // trim only if erase would outlast the abort time
        cutShort_reg <= busy_reg && (runCmd_reg == CMD_SECT) &&
                        (opCnt_reg > TICKS_ABORT);
      end else if (finish || !busy_reg) begin
        abortAct_reg <= 1'b0;
        cutShort_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // timing engine and pump
  // pump stays on across a held burst so the next byte starts fast

  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy_reg    <= 1'b0;
      runCmd_reg  <= CMD_RST;
      runAddr_reg <= 16'h0000;
      opCnt_reg   <= 15'h0000;
      pre_reg     <= 7'h00;
      pump_reg    <= 1'b0;
    end else if (errStop) begin
      busy_reg <= 1'b0;
      pump_reg <= 1'b0;
      pre_reg  <= 7'h00;
    end else if (start) begin
      pre_reg <= 7'h00;
      if (startBlk) begin
        pump_reg <= 1'b0;
      end else begin
        busy_reg    <= 1'b1;
        runCmd_reg  <= bufCmd_reg;
        runAddr_reg <= bufAddr_reg;
        opCnt_reg   <= startTicks;
        pump_reg    <= (bufCmd_reg != CMD_BLANK);
      end
    end else if (busy_reg) begin
      pre_reg <= tick ? 7'h00 : pre_reg + 7'h01;
      if (launch && isAbort && runCmd_reg == CMD_SECT &&
          opCnt_reg > TICKS_ABORT) begin
        // abort shortens erase to the abort time
        opCnt_reg <= TICKS_ABORT;
      end else if (finish) begin
        // done flag follows from busy low
        busy_reg <= 1'b0;
        // off unless a burst ends with a burst queued or any sequence being entered at the next address in the same 32-byte block
        pump_reg <= keepPump;
      end else if (tick) begin
        opCnt_reg <= opCnt_reg - 15'h0001;
      end
    end else if (!bufFull_reg && seq_reg == SEQ_IDLE) begin
      // held pump released once the follow-up never came
      pump_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // read data and vector fetch
  // the vector path costs one cycle on every fetch, redirected or not

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_reg  <= 8'h00;
      vec_reg <= 16'h0000;
    end else begin
      // data stand only in the cycle after the strobe
      rd_reg <= busRd ? rdMux : 8'h00;
      // shift below protected start, reset vector kept
      vec_reg <= (vecFetch && redirOn && inVec) ? (vecAddr - flSize) : vecAddr;
    end
  end

  assign busRdData  = rd_reg;
  assign vecAddrOut = vec_reg;
  assign pumpOn     = pump_reg;
  assign arrayBusy  = busy_reg;

endmodule

// ---- tb/ncg_host_model.sv ----
`timescale 1ns/1ps
// cpu-side bus master: one strobe a cycle, idle cycle after each access
module ncg_host_model
  import ncg_pkg::*;
(
  input  wire logic        core_clk,
  output logic      [15:0] busAddr,
  output logic      [7:0]  busWrData,
  output logic             busWr,
  output logic             busRd,
  input  wire logic [7:0]  busRdData
);
  // quiet bus from time zero
  initial begin
    busAddr   = 16'h0000;
    busWrData = 8'h00;
    busWr     = 1'b0;
    busRd     = 1'b0;
  end

  // one write, held until the sampling edge
  task automatic wrReg(input logic [15:0] a, input logic [7:0] d);
    busAddr   <= a;
    busWrData <= d;
    busWr     <= 1'b1;
    @(posedge core_clk);
    busWr     <= 1'b0;
    // released data flips so a stale byte is never reused
    busWrData <= ~d;
    @(posedge core_clk);
  endtask

  // one read, data taken in the single cycle it stands
  task automatic rdReg(input logic [15:0] a, output logic [7:0] d);
    busAddr <= a;
    busRd   <= 1'b1;
    @(posedge core_clk);
    busRd   <= 1'b0;
    @(negedge core_clk);
    d = busRdData;
    @(posedge core_clk);
  endtask

  task automatic cmdSeq(input logic [15:0] a, input logic [7:0] code);
    wrReg(a, 8'h5a);
    wrReg(REG_CMD, code);
    wrReg(REG_STAT, 8'h80);
  endtask

  task automatic clearErr();
    wrReg(REG_STAT, 8'h30);
  endtask
endmodule

// ---- tb/ncg_guard_assertions.sv ----
`timescale 1ns/1ps
// port-level watcher of the command guard
module ncg_guard_assertions
  import ncg_pkg::*;
#(
  parameter int unsigned TICKS_MASS = TICKS_MASS_DEF
) (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic [15:0] busAddr,
  input wire logic [7:0]  busWrData,
  input wire logic        busWr,
  input wire logic        busRd,
  input wire logic [7:0]  busRdData,
  input wire logic        stopReq,
  input wire logic [7:0]  nvOptByte,
  input wire logic        vecFetch,
  input wire logic [15:0] vecAddr,
  input wire logic [15:0] vecAddrOut,
  input wire logic        pumpOn,
  input wire logic        arrayBusy
);
  logic divSeen_reg;  // divider written since reset
  logic errSeen_reg;  // a status read showed the error
  logic statRd_reg;   // previous cycle read status

  // helper flags; only a host clear forgets a seen error
  always_ff @(posedge core_clk) begin
    if (srst) begin
      divSeen_reg <= 1'b0;
      errSeen_reg <= 1'b0;
      statRd_reg  <= 1'b0;
    end else begin
      statRd_reg <= busRd && busAddr == REG_STAT;
      if (busWr && busAddr == REG_DIV) divSeen_reg <= 1'b1;
      if (busWr && busAddr == REG_STAT && busWrData[ST_ACCESS_ERROR_ALIAS]) errSeen_reg <= 1'b0;
      else if (statRd_reg && busRdData[ST_ACCESS_ERROR_ALIAS]) errSeen_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence heldErrRead;
    errSeen_reg && busRd && busAddr == REG_STAT;
  endsequence
  sequence stopHit;
    stopReq && arrayBusy;
  endsequence

  ////////////////////////////////////////////////////////////
  chk_rd_idle: assert property (!busRd |=> busRdData == 8'h00)
    else $error("read data not zero outside read cycle");
  chk_opt_copy: assert property (
    busRd && busAddr == REG_OPT |=> busRdData == nvOptByte)
    else $error("option copy differs from option byte");
  chk_gap_zero: assert property (
    busRd && busAddr > REG_CMD && busAddr < FL_LO |=> busRdData == 8'h00)
    else $error("unmapped read not zero");
  chk_vec_pass: assert property (
    vecFetch && !(vecAddr inside {[VEC_LO:VEC_HI]}) |=> vecAddrOut == $past(vecAddr))
    else $error("non-vector fetch address altered");
  chk_vec_low: assert property (
    vecFetch |=> vecAddrOut[8:0] == $past(vecAddr[8:0]))
    else $error("redirect moved address by a non-block amount");
  chk_no_redirect: assert property (
    vecFetch && nvOptByte[OPT_NORED] |=> vecAddrOut == $past(vecAddr))
    else $error("vector redirected while disabled");
  chk_stop_abort: assert property (stopHit |-> ##[1:3] !arrayBusy)
    else $error("stop did not abort operation");
  chk_pump_off: assert property (!arrayBusy [*8] |-> !pumpOn)
    else $error("pump left on while idle");
  chk_div_first: assert property (!divSeen_reg |-> !arrayBusy)
    else $error("operation ran before divider write");
  chk_err_sticky: assert property (heldErrRead |=> busRdData[ST_ACCESS_ERROR_ALIAS])
    else $error("access error dropped without clear");
  chk_err_blocks: assert property (errSeen_reg && !arrayBusy |=> !arrayBusy)
    else $error("command started while access error set");
endmodule

bind ncg_nvm_command_guard ncg_guard_assertions #(.TICKS_MASS(TICKS_MASS)) chk_u (
  .core_clk(core_clk), .srst(srst), .busAddr(busAddr), .busWrData(busWrData),
  .busWr(busWr), .busRd(busRd), .busRdData(busRdData), .stopReq(stopReq),
  .nvOptByte(nvOptByte), .vecFetch(vecFetch), .vecAddr(vecAddr),
  .vecAddrOut(vecAddrOut), .pumpOn(pumpOn), .arrayBusy(arrayBusy)
);

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
  import ncg_pkg::*;
  logic        core_clk;      // 10 MHz core clock
  logic        srst;          // sync reset
  logic [15:0] busAddr;       // host address
  logic [7:0]  busWrData;     // host write data
  logic        busWr;         // write strobe
  logic        busRd;         // read strobe
  logic [7:0]  busRdData;     // read data
  logic        bdmAccess;     // debug-originated write
  logic        secured;       // part secured
  logic        stopReq;       // stop entry
  logic [7:0]  nvProtByte;    // protection byte
  logic [7:0]  nvOptByte;     // option byte
  logic        vecFetch;      // vector fetch
  logic [15:0] vecAddr;       // fetch address
  logic [15:0] vecAddrOut;    // redirected address
  logic        pumpOn;        // high voltage on
  logic        arrayBusy;     // operation running
  int          failCount;      // mismatches
  int          samplesChecked; // comparisons
  int          pumpFalls = 0;  // pump switch-offs seen
  int          busyCycles = 0; // cycles with an operation running
  int          fallsBase;      // counts taken before the burst series
  int          busyBase;
  localparam int TICK_CYC = 4; // divider 3: one timing tick per four cycles
  // all six legal codes
  logic [7:0]  codes [6] = '{CMD_BLANK, CMD_PROG, CMD_BURST, CMD_SECT, CMD_MASS, CMD_ABORT};
  // broken sequences as {addr, data}, zero ends early
  logic [23:0] badSeq [6][3] = '{
    '{24'h1a0000, 24'h1a0100, 24'h000000},   // second array write
    '{24'h1a0000, 24'h182200, 24'h000000},   // other register after array
    '{24'h1a0000, 24'h182420, 24'h182420},   // second code
    '{24'h1a0000, 24'h182420, 24'h182003},   // divider after code
    '{24'h1a0000, 24'h182300, 24'h000000},   // zero to buffer-empty
    '{24'h1a0000, 24'h182421, 24'h000000}};  // illegal code

  ncg_nvm_command_guard #(.TICKS_MASS(20)) dut_u (
    .core_clk(core_clk), .srst(srst), .busAddr(busAddr), .busWrData(busWrData),
    .busWr(busWr), .busRd(busRd), .busRdData(busRdData), .bdmAccess(bdmAccess),
    .secured(secured), .stopReq(stopReq), .nvProtByte(nvProtByte),
    .nvOptByte(nvOptByte), .vecFetch(vecFetch), .vecAddr(vecAddr),
    .vecAddrOut(vecAddrOut), .pumpOn(pumpOn), .arrayBusy(arrayBusy)
  );
  ncg_host_model host_u (
    .core_clk(core_clk), .busAddr(busAddr), .busWrData(busWrData),
    .busWr(busWr), .busRd(busRd), .busRdData(busRdData)
  );

  ////////////////////////////////////////////////////////////
  // free-running clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // counts pump drops and busy cycles for the burst checks
  always @(posedge core_clk) begin
    if ($fell(pumpOn)) pumpFalls <= pumpFalls + 1;
    if (arrayBusy) busyCycles <= busyCycles + 1;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic expReg(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rdReg(a, d);
    check({8'h00, d}, {8'h00, e});
  endtask
  task automatic expStat(input int b, input logic e);
    logic [7:0] d;
    host_u.rdReg(REG_STAT, d);
    check({15'h0, d[b]}, {15'h0, e});
  endtask
  // bounded poll of one status bit; running out ends the run
  task automatic waitStat(input int b);
    logic [7:0] d;
    d = 8'h00;
    for (int n = 0; n < 20000 && d[b] !== 1'b1; n++) host_u.rdReg(REG_STAT, d);
    if (d[b] !== 1'b1) begin
      failCount++;
      $display("unexpected at %0t: status wait ran out", $time);
      reportAndStop();
    end
  endtask
  task automatic expVec(input logic [15:0] a, input logic [15:0] e);
    vecFetch <= 1'b1;
    vecAddr  <= a;
    @(posedge core_clk);
    vecFetch <= 1'b0;
    @(negedge core_clk);
    check(vecAddrOut, e);
    @(posedge core_clk);
  endtask
  task automatic doReset(input logic [7:0] p, input logic [7:0] o);
    srst       <= 1'b1;
    nvProtByte <= p;
    nvOptByte  <= o;
    repeat (16) @(posedge core_clk);
    srst       <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    failCount = 0;
    samplesChecked = 0;
    srst = 1'b1;
    bdmAccess = 1'b0;
    secured = 1'b0;
    stopReq = 1'b0;
    vecFetch = 1'b0;
    vecAddr = 16'h0000;
    nvProtByte = 8'h00;
    nvOptByte = 8'h00;
    doReset(8'h00, 8'h40);
    expReg(REG_OPT, 8'h40);
    expReg(REG_PROT, 8'h00);
    expReg(16'h1830, 8'h00);
    expVec(16'hffe0, 16'hffe0);
    host_u.wrReg(16'h1a00, 8'h00);
    expStat(ST_ACCESS_ERROR_ALIAS, 1'b1);
    host_u.wrReg(16'h1830, 8'hff);
    expStat(ST_ACCESS_ERROR_ALIAS, 1'b1);
    host_u.clearErr();
    expStat(ST_ACCESS_ERROR_ALIAS, 1'b0);
    host_u.wrReg(REG_DIV, 8'h03);
    expReg(REG_DIV, 8'h83);
    // each broken sequence, then a refused legal one
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 3; j++)
        if (badSeq[i][j] != 24'h0) host_u.wrReg(badSeq[i][j][23:8], badSeq[i][j][7:0]);
      host_u.cmdSeq(16'h1a00, CMD_PROG);
      expStat(ST_ACCESS_ERROR_ALIAS, 1'b1);
      @(negedge core_clk);
      check({15'h0, arrayBusy}, 16'h0000);
      @(posedge core_clk);
      host_u.clearErr();
      expStat(ST_ACCESS_ERROR_ALIAS, 1'b0);
    end
    // every code from the cpu, then from secured debug
    for (int p = 0; p < 2; p++) begin
      secured   <= p[0];
      bdmAccess <= p[0];
      for (int i = 0; i < 6; i++) begin
        host_u.cmdSeq(16'h1a40, codes[i]);
        waitStat(ST_CCF);
        expStat(ST_ACCESS_ERROR_ALIAS, p[0] && !(codes[i] inside {CMD_BLANK, CMD_MASS}));
        host_u.clearErr();
      end
    end
    secured   <= 1'b0;
    bdmAccess <= 1'b0;
    // burst across a block edge, next one queued early
    fallsBase = pumpFalls;
    busyBase  = busyCycles;
    host_u.cmdSeq(16'h1a1e, CMD_BURST);
    for (int i = 0; i < 2; i++) begin
      waitStat(ST_CBEF);
      host_u.cmdSeq(16'h1a1f + 16'(i), CMD_BURST);
    end
    waitStat(ST_CCF);
    repeat (60) @(posedge core_clk);
    check(16'(pumpFalls - fallsBase), 16'h0002);
    check(16'(busyCycles - busyBase), 16'(TICK_CYC * (2 * TICKS_PROG + TICKS_BURST)));
    // abort cutting an erase, second pass starts a sequence meanwhile
    for (int k = 0; k < 2; k++) begin
      host_u.cmdSeq(16'h1a00, CMD_SECT);
      waitStat(ST_CBEF);
      host_u.cmdSeq(16'h1a00, CMD_ABORT);
      if (k == 1) host_u.wrReg(16'h1a00, 8'h00);
      else expStat(ST_CBEF, 1'b0);
      waitStat(ST_CCF);
      expStat(ST_ACCESS_ERROR_ALIAS, 1'b1);
      host_u.clearErr();
    end
    // stop entry during a program
    host_u.cmdSeq(16'h1a50, CMD_PROG);
    stopReq <= 1'b1;
    repeat (4) @(posedge core_clk);
    stopReq <= 1'b0;
    @(negedge core_clk);
    check({15'h0, arrayBusy}, 16'h0000);
    @(posedge core_clk);
    expStat(ST_ACCESS_ERROR_ALIAS, 1'b1);
    host_u.clearErr();
    // second reset: flash and eeprom protected, redirect on
    doReset(8'h23, 8'h00);
    host_u.wrReg(REG_DIV, 8'h03);
    expVec(16'hffe0, 16'hf9e0);
    expVec(16'hfffe, 16'hfffe);
    for (int i = 0; i < 2; i++) begin
      host_u.cmdSeq(i ? 16'hfa10 : 16'h17c0, CMD_PROG);
      expStat(ST_PVIOL, 1'b1);
      host_u.clearErr();
    end
    host_u.wrReg(REG_PROT, 8'h21);
    expReg(REG_PROT, 8'h23);
    host_u.wrReg(REG_PROT, 8'h25);
    expReg(REG_PROT, 8'h25);
    expVec(16'hffe0, 16'hf5e0);
    reportAndStop();
  end
endmodule
